// ===== logic/flash_pump_status_and_boot_entry.sv
// pump status and power register with parallel port, and boot or user mode entry
//
// Operation
// - bit 8: erase power and negative below threshold
// - bit 7: negative pump discharged above threshold
// - bit 6: pumping while core supply low
// - bits 5:4 pick negative level under erase
// - bits 1:0 pick positive level when powered
// - verify enable switches positive level decoding
// - parallel write loads bits 5:0 only
// - parallel read drives all nine bits
// - internal bus access outside parallel mode
// - bits 3:2 reserved, zero
// - mode 6 or 7 enters boot
// - serial boot maps boot rom at zero
// - boot sets 38400 bps, loads via uart0
// - loader stored in ram window only
// - measure host low period for rate sync
// - mode 4 or 5 enables flash, user mode
// - erase/program power enable their pumps
// - verify bits enable positive gate pump
`timescale 1ns/10ps
`default_nettype none

module flash_pump_status_and_boot_entry #(
    parameter int MEAS_W = 16
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // mode pins, sampled after reset release
    input wire logic [2:0] mode_pins,
    // flash control register bits, same clock
    input wire logic prog_pump_on,
    input wire logic erase_pump_on,
    input wire logic prog_verify_on,
    input wire logic erase_verify_on,
    // analog comparators, asynchronous
    input wire logic neg_below_reach_level,
    input wire logic neg_above_disch_level,
    input wire logic core_supply_low,
    // internal bus access to this register
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [8:0] bus_wdata,
    output logic [8:0] bus_rdata,
    // parallel programming port
    input wire logic [2:0] prom_reg_select,
    input wire logic prom_write_strobe_n,
    input wire logic prom_output_enable_n,
    input wire logic [15:0] prom_data_bus_in,
    output logic [15:0] prom_data_bus_out,
    output logic [15:0] prom_data_bus_oe,
    // pump controls
    output logic drain_pump_en,
    output logic pos_gate_pump_en,
    output logic neg_gate_pump_en,
    output logic [3:0] neg_gate_volts,
    output logic [3:0] pos_gate_volts,
    // mode entry
    output logic serial_boot_select,
    output logic boot_rom_at_zero,
    output logic flash_enable,
    output logic user_program_mode,
    output logic expanded_bus,
    output logic prom_mode,
    // boot download
    input wire logic uart0_rx_pin,
    input wire logic loader_byte_valid,
    input wire logic [7:0] loader_byte,
    output logic [15:0] uart0_baud_div,
    output logic [MEAS_W-1:0] host_low_cycles,
    output logic host_rate_locked,
    output logic ram_wr_en,
    output logic [31:0] ram_wr_addr,
    output logic [7:0] ram_wr_data,
    output logic loader_full
);

    // ==========================================================
    // level decoders
    // negative gate level under erase power
    function automatic logic [3:0] neg_level(input logic [1:0] code);
        case (code)
            2'b00: neg_level = flash_pump_pkg::V9;
            2'b01: neg_level = flash_pump_pkg::V10;
            2'b10: neg_level = flash_pump_pkg::V8;
            default: neg_level = flash_pump_pkg::V10;
        endcase
    endfunction
    // positive gate level, verify or program/erase table
    function automatic logic [3:0] pos_level(input logic [1:0] code, input logic vfy);
        if (vfy) begin
            case (code)
                2'b00: pos_level = flash_pump_pkg::V4;
                2'b01: pos_level = flash_pump_pkg::V5;
                2'b10: pos_level = flash_pump_pkg::V6;
                default: pos_level = flash_pump_pkg::V7;
            endcase
        end else begin
            case (code)
                2'b00: pos_level = flash_pump_pkg::V9;
                2'b01: pos_level = flash_pump_pkg::V8;
                2'b10: pos_level = flash_pump_pkg::V10;
                default: pos_level = flash_pump_pkg::V7;
            endcase
        end
    endfunction

    // ==========================================================
    // synchronisers for pins and comparators
    logic [2:0] cmp_meta_q;  // first stage, read only by the second
    logic [2:0] cmp_sync_q;  // reached, discharged, supply low
    logic [2:0] mode_meta_q; // first stage of mode pins
    logic [2:0] mode_sync_q; // synchronised mode pins
    logic [4:0] prom_meta_q; // select, strobe, output enable first stage
    logic [4:0] prom_sync_q; // synchronised parallel controls
    logic strobe_prev_q;     // delayed strobe for edge detect
    logic [5:0] pdata_meta_q; // parallel data first stage
    logic [5:0] pdata_sync_q; // parallel data second stage

    // every async input sees two flops before use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_q <= 3'h0;
            cmp_sync_q <= 3'h0;
            mode_meta_q <= 3'h0;
            mode_sync_q <= 3'h0;
            prom_meta_q <= 5'h03;
            prom_sync_q <= 5'h03;
            strobe_prev_q <= 1'b1;
            pdata_meta_q <= 6'h00;
            pdata_sync_q <= 6'h00;
        end else if (clk_en) begin
            cmp_meta_q <= {core_supply_low, neg_above_disch_level, neg_below_reach_level};
            cmp_sync_q <= cmp_meta_q;
            mode_meta_q <= mode_pins;
            mode_sync_q <= mode_meta_q;
            prom_meta_q <= {prom_reg_select, prom_write_strobe_n, prom_output_enable_n};
            prom_sync_q <= prom_meta_q;
            strobe_prev_q <= prom_sync_q[1];
            pdata_meta_q <= prom_data_bus_in[5:0];
            pdata_sync_q <= pdata_meta_q;
        end
    end

    // ==========================================================
    // mode strap capture, once after reset release
    logic [1:0] strap_cnt_q; // settling count for the pin synchroniser
    logic strap_done_q;      // mode has been caught
    logic [2:0] mode_q;      // caught mode

    wire strap_take = !strap_done_q && strap_cnt_q == flash_pump_pkg::STRAP_WAIT;
    // the strap is caught by a clocked process, never by the reset itself
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            mode_q <= 3'h0;
        end else if (clk_en) begin
            if (!strap_done_q) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            if (strap_take) begin
                mode_q <= mode_sync_q;
                strap_done_q <= 1'b1;
            end
        end
    end

    wire in_prom = strap_done_q && mode_q == flash_pump_pkg::MODE_PROM;
    wire in_boot = strap_done_q && (mode_q == flash_pump_pkg::MODE_BOOT_EXP
                                 || mode_q == flash_pump_pkg::MODE_BOOT_ONE);
    wire in_user = strap_done_q && (mode_q == flash_pump_pkg::MODE_USER_EXP
                                 || mode_q == flash_pump_pkg::MODE_USER_ONE);
    wire expanded = mode_q == flash_pump_pkg::MODE_BOOT_EXP
                 || mode_q == flash_pump_pkg::MODE_USER_EXP;
    // ==========================================================
    // register access decode
    logic [5:0] ctrl_q;      // writable control bits, reserved kept zero
    logic [2:0] status_q;    // registered status bits 8..6

    wire [2:0] psel = prom_sync_q[4:2];
    wire pstrobe = prom_sync_q[1];
    wire prom_hit = in_prom && psel == flash_pump_pkg::SEL_PUMP_REG;
    wire prom_wr = prom_hit && pstrobe && !strobe_prev_q;
    wire prom_rd = prom_hit && pstrobe;
    wire bus_write = !in_prom && bus_sel && bus_wr;
    wire bus_read = !in_prom && bus_sel && !bus_wr;
    wire [8:0] reg_view = {status_q, ctrl_q & flash_pump_pkg::CTRL_MASK};

    // control bits: parallel writer in its mode, internal bus otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= flash_pump_pkg::REG_RESET[5:0];
        end else if (clk_en) begin
            if (prom_wr) begin
                ctrl_q <= pdata_sync_q & flash_pump_pkg::CTRL_MASK;
            end else if (bus_write) begin
                ctrl_q <= bus_wdata[5:0] & flash_pump_pkg::CTRL_MASK;
            end
        end
    end

    // ==========================================================
    // pump status flags, read only, never touched by writes
    wire any_pump = prog_pump_on | erase_pump_on;
    wire reach_now = erase_pump_on & cmp_sync_q[0];
    wire disch_now = cmp_sync_q[1];
    wire lowv_now = any_pump & cmp_sync_q[2];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= flash_pump_pkg::REG_RESET[8:6];
        end else if (clk_en) begin
            status_q <= {reach_now, disch_now, lowv_now};
        end
    end

    // ==========================================================
    // read paths
    // internal bus read data holds the last read value
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 9'h000;
        end else if (clk_en && bus_read) begin
            bus_rdata <= reg_view;
        end
    end

    // parallel port drives nine bits while selected with strobe high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prom_data_bus_out <= 16'h0000;
            prom_data_bus_oe <= 16'h0000;
        end else if (clk_en) begin
            prom_data_bus_out <= prom_rd ? {7'h00, reg_view} : 16'h0000;
            prom_data_bus_oe <= prom_rd ? 16'h01ff : 16'h0000;
        end
    end

    // ==========================================================
    // pump enables and level selection
    wire vfy = prog_verify_on | erase_verify_on;
    wire pos_on = any_pump | vfy;
    wire [3:0] neg_v = erase_pump_on ? neg_level(ctrl_q[5:4]) : 4'h0;
    wire [3:0] pos_v = pos_on ? pos_level(ctrl_q[1:0], vfy) : 4'h0;

    // verify decoding wins over program/erase decoding
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drain_pump_en <= 1'b0;
            pos_gate_pump_en <= 1'b0;
            neg_gate_pump_en <= 1'b0;
            neg_gate_volts <= 4'h0;
            pos_gate_volts <= 4'h0;
        end else if (clk_en) begin
            drain_pump_en <= prog_pump_on;
            neg_gate_pump_en <= erase_pump_on;
            pos_gate_pump_en <= pos_on;
            neg_gate_volts <= neg_v;
            pos_gate_volts <= pos_v;
        end
    end

    // ==========================================================
    // mode outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_boot_select <= 1'b0;
            boot_rom_at_zero <= 1'b0;
            flash_enable <= 1'b0;
            user_program_mode <= 1'b0;
            expanded_bus <= 1'b0;
            prom_mode <= 1'b0;
        end else if (clk_en) begin
            serial_boot_select <= in_boot;
            boot_rom_at_zero <= in_boot;
            flash_enable <= in_user;
            user_program_mode <= in_user;
            expanded_bus <= strap_done_q && expanded;
            prom_mode <= in_prom;
        end
    end

    // ==========================================================
    // host rate measurement on uart channel 0
    flash_pump_pkg::boot_state_t state_q; // boot download state
    flash_pump_pkg::boot_state_t state_d;
    logic meas_valid;                     // meter has a low period
    logic [MEAS_W-1:0] meas_cycles;       // measured low period

    low_period_meter #(
        .CNT_W(MEAS_W)
    ) u_meter (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .arm(state_q != flash_pump_pkg::BOOT_IDLE),
        .rx_pin(uart0_rx_pin),
        .low_cycles_q(meas_cycles),
        .valid_q(meas_valid)
    );

    // ==========================================================
    // boot download sequence
    logic [31:0] wr_ptr_q; // next ram byte address
    wire at_last = wr_ptr_q == flash_pump_pkg::LOADER_LAST;
    wire take_byte = state_q == flash_pump_pkg::BOOT_LOAD && loader_byte_valid;
    // idle until boot entry, sync to host, load, then stop at window end
    always_comb begin
        state_d = state_q;
        case (state_q)
            flash_pump_pkg::BOOT_IDLE: if (in_boot) state_d = flash_pump_pkg::BOOT_SYNC;
            flash_pump_pkg::BOOT_SYNC: if (meas_valid) state_d = flash_pump_pkg::BOOT_LOAD;
            flash_pump_pkg::BOOT_LOAD:
                if (take_byte && at_last) state_d = flash_pump_pkg::BOOT_DONE;
            flash_pump_pkg::BOOT_DONE: state_d = flash_pump_pkg::BOOT_DONE;
            default: state_d = flash_pump_pkg::BOOT_IDLE;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= flash_pump_pkg::BOOT_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end
    // baud divisor preset on boot entry for the assumed core clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            uart0_baud_div <= 16'h0000;
            host_low_cycles <= '0;
            host_rate_locked <= 1'b0;
        end else if (clk_en) begin
            if (state_q == flash_pump_pkg::BOOT_IDLE && in_boot) begin
                uart0_baud_div <= flash_pump_pkg::BOOT_BAUD_DIV;
            end
            if (state_q == flash_pump_pkg::BOOT_SYNC && meas_valid) begin
                host_low_cycles <= meas_cycles;
                host_rate_locked <= 1'b1;
            end
        end
    end
    // loader bytes go to ram; the pointer never leaves the window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= flash_pump_pkg::LOADER_BASE;
            ram_wr_en <= 1'b0;
            ram_wr_addr <= flash_pump_pkg::LOADER_BASE;
            ram_wr_data <= 8'h00;
            loader_full <= 1'b0;
        end else if (clk_en) begin
            ram_wr_en <= take_byte;
            if (take_byte) begin
                ram_wr_addr <= wr_ptr_q;
                ram_wr_data <= loader_byte;
                if (!at_last) begin
                    wr_ptr_q <= wr_ptr_q + 32'h1;
                end
            end
            loader_full <= state_d == flash_pump_pkg::BOOT_DONE;
        end
    end

endmodule

`default_nettype wire

// ===== logic/flash_pump_pkg.sv
// shared constants for the pump status register and programming entry logic
package flash_pump_pkg;

    // ==========================================================
    // pump status and power register layout
    localparam int NEG_SEL_HI = 5;               // negative level select msb
    localparam int NEG_SEL_LO = 4;               // negative level select lsb
    localparam int POS_SEL_HI = 1;               // positive level select msb
    localparam int POS_SEL_LO = 0;               // positive level select lsb
    localparam logic [8:0] REG_RESET = 9'h000;   // register reset value
    localparam logic [5:0] CTRL_MASK = 6'h33;    // bits 3..2 reserved, kept zero

    // ==========================================================
    // parallel programming port
    localparam logic [2:0] SEL_PUMP_REG = 3'h5;  // register-select code of this register

    // ==========================================================
    // mode pin encodings
    localparam logic [2:0] MODE_PROM = 3'h1;     // parallel writer mode
    localparam logic [2:0] MODE_USER_EXP = 3'h4; // user program, expanded bus
    localparam logic [2:0] MODE_USER_ONE = 3'h5; // user program, single chip
    localparam logic [2:0] MODE_BOOT_EXP = 3'h6; // boot, expanded bus
    localparam logic [2:0] MODE_BOOT_ONE = 3'h7; // boot, single chip
    localparam logic [1:0] STRAP_WAIT = 2'h2;    // cycles after release before capture

    // ==========================================================
    // boot download
    localparam longint BOOT_CORE_HZ = 33860000;  // core clock assumed by boot program
    localparam longint BOOT_BAUD = 38400;        // host bit rate in bps
    localparam logic [15:0] BOOT_BAUD_DIV = 16'(BOOT_CORE_HZ / (16 * BOOT_BAUD));
    localparam logic [31:0] LOADER_BASE = 32'h0803_0000; // first loader byte
    localparam logic [31:0] LOADER_LAST = 32'h0803_ffff; // last loader byte

    // ==========================================================
    // gate voltage codes in whole volts (magnitude)
    localparam logic [3:0] V4 = 4'h4;
    localparam logic [3:0] V5 = 4'h5;
    localparam logic [3:0] V6 = 4'h6;
    localparam logic [3:0] V7 = 4'h7;
    localparam logic [3:0] V8 = 4'h8;
    localparam logic [3:0] V9 = 4'h9;
    localparam logic [3:0] V10 = 4'ha;

    // boot download sequence, gray along the usual path
    typedef enum logic [1:0] {
        BOOT_IDLE = 2'b00,
        BOOT_SYNC = 2'b01,
        BOOT_LOAD = 2'b11,
        BOOT_DONE = 2'b10
    } boot_state_t;

endpackage

// ===== logic/low_period_meter.sv
// measures the first low period on the serial boot line
`timescale 1ns/10ps
`default_nettype none

module low_period_meter #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // control
    input wire logic arm,                    // level: measuring allowed
    // serial line from the pin
    input wire logic rx_pin,
    // result
    output logic [CNT_W-1:0] low_cycles_q,   // measured low period in clocks
    output logic valid_q                     // level: a low period was caught
);

    // ==========================================================
    // pin synchroniser
    logic rx_meta_q;   // first stage, read only by the second
    logic rx_sync_q;   // second stage
    logic rx_prev_q;   // previous synchronised level for edges
    logic [CNT_W-1:0] run_q; // running low count

    wire fall = rx_prev_q & ~rx_sync_q;
    wire rise = ~rx_prev_q & rx_sync_q;
    wire run_max = &run_q;

    // two flops before any logic sees the line
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (clk_en) begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // ==========================================================
    // low run counter, saturating so a stuck line cannot wrap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= '0;
        end else if (clk_en) begin
            if (fall) begin
                run_q <= CNT_W'(1);
            end else if (!rx_sync_q && !run_max) begin
                run_q <= run_q + CNT_W'(1);
            end
        end
    end

    // capture on the rising edge that ends the first low run after arming
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_cycles_q <= '0;
            valid_q <= 1'b0;
        end else if (clk_en) begin
            if (!arm) begin
                valid_q <= 1'b0;
            end else if (rise && !valid_q && run_q != '0) begin
                low_cycles_q <= run_q;
                valid_q <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== dv/host_uart_model.sv
// host side model: serial loader frames on the boot line
`timescale 1ns/10ps
`default_nettype none
module host_uart_model #(
    parameter int BIT = 32 // shortened bit time in clocks
) (
    // clock
    input wire logic clock,
    // serial line and received byte, standing in for the on-chip receiver
    output logic rx,
    output logic vld,
    output logic [7:0] dat
);
    // line idles high between frames
    initial begin
        rx = 1'b1;
        vld = 1'b0;
        dat = 8'h00;
    end
    // ==========================================================
    // one frame: start, eight data bits lsb first, one stop, no parity
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx = f[i];
            repeat (BIT) @(negedge clock);
        end
        dat = b;
        vld = 1'b1;
        @(negedge clock);
        vld = 1'b0;
        dat = ~b; // stale byte must not look valid
    endtask
endmodule
`default_nettype wire

// ===== dv/pump_monitor.sv
// concurrent checks on the pump register and mode entry ports
`timescale 1ns/10ps
`default_nettype none
module pump_monitor (
    // clock and reset
    input wire logic clock, rst_n, clk_en,
    // control inputs and loader strobe
    input wire logic prog_pump_on, erase_pump_on, prog_verify_on, erase_verify_on,
    input wire logic loader_byte_valid, ram_wr_en,
    // observed outputs
    input wire logic [8:0] bus_rdata,
    input wire logic [15:0] prom_data_bus_out, prom_data_bus_oe, uart0_baud_div,
    input wire logic drain_pump_en, pos_gate_pump_en, serial_boot_select, boot_rom_at_zero,
    input wire logic flash_enable, user_program_mode, prom_mode,
    input wire logic [3:0] neg_gate_volts,
    input wire logic [31:0] ram_wr_addr
);
    // ==========================================================
    // single domain, so one clock and one disable
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_boot_entry;
        $rose(serial_boot_select);
    endsequence
    a_reserved_zero: assert property (bus_rdata[3:2] == 2'h0)
        else $error("reserved bits");
    a_neg_off: assert property ($past(!erase_pump_on && clk_en) |-> neg_gate_volts == 4'h0)
        else $error("neg level");
    a_drain_on: assert property ($past(prog_pump_on && clk_en) |-> drain_pump_en)
        else $error("drain pump");
    a_verify_pump: assert property ($past((prog_verify_on || erase_verify_on) && clk_en)
        |-> pos_gate_pump_en) else $error("verify pump");
    a_rom_map: assert property (s_boot_entry |-> ##[0:1] boot_rom_at_zero)
        else $error("rom map");
    a_baud_set: assert property (s_boot_entry |-> ##[0:2] uart0_baud_div == 16'h0037)
        else $error("baud divisor");
    a_ram_window: assert property (ram_wr_en |-> $past(loader_byte_valid)
        && ram_wr_addr >= 32'h0803_0000 && ram_wr_addr <= 32'h0803_ffff)
        else $error("ram window");
    a_prom_drive: assert property (prom_data_bus_oe != 16'h0 |-> prom_mode
        && prom_data_bus_oe == 16'h01ff && prom_data_bus_out[15:9] == 7'h00)
        else $error("prom drive");
    a_user_mode: assert property (user_program_mode |-> flash_enable && !serial_boot_select)
        else $error("user mode");
endmodule
bind flash_pump_status_and_boot_entry pump_monitor u_mon (.*);
`default_nettype wire

// ===== dv/tb_top.sv
// testbench: register, parallel port, mode entry and boot download
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int BIT = 32; // host bit time in clocks
    logic clock, rst_n, clk_en, prog_pump_on, erase_pump_on, prog_verify_on, erase_verify_on;
    logic neg_below_reach_level, neg_above_disch_level, core_supply_low, bus_sel, bus_wr;
    logic prom_write_strobe_n, prom_output_enable_n, uart0_rx_pin, loader_byte_valid;
    logic drain_pump_en, pos_gate_pump_en, neg_gate_pump_en, serial_boot_select, boot_rom_at_zero;
    logic flash_enable, user_program_mode, expanded_bus, prom_mode, host_rate_locked;
    logic ram_wr_en, loader_full;
    logic [2:0] mode_pins, prom_reg_select;
    logic [3:0] neg_gate_volts, pos_gate_volts;
    logic [7:0] loader_byte, ram_wr_data;
    logic [8:0] bus_wdata, bus_rdata;
    logic [15:0] prom_data_bus_in, prom_data_bus_out, prom_data_bus_oe, uart0_baud_div;
    logic [15:0] host_low_cycles;
    logic [31:0] ram_wr_addr;
    logic [39:0] wq[$]; // captured ram writes, address then byte
    logic [3:0] neg_tab [4] = '{4'h9, 4'ha, 4'h8, 4'ha};
    logic [3:0] pos_tab [4] = '{4'h9, 4'h8, 4'ha, 4'h7};
    int miscompares = 0;
    int checks = 0;
    flash_pump_status_and_boot_entry DUT (.*);
    host_uart_model #(.BIT(BIT)) host (.clock(clock), .rx(uart0_rx_pin),
        .vld(loader_byte_valid), .dat(loader_byte));
    // ==========================================================
    // clock, ram write capture and watchdog
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(negedge clock) if (ram_wr_en === 1'b1) wq.push_back({ram_wr_addr, ram_wr_data});
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
    // ==========================================================
    // shared tasks
    task automatic print_verdict();
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] d);
        @(negedge clock);
        bus_sel = 1'b1;
        bus_wr = 1'b1;
        bus_wdata = d;
        @(negedge clock);
        bus_sel = 1'b0;
        bus_wr = 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [8:0] e);
        @(negedge clock);
        bus_sel = 1'b1;
        @(negedge clock);
        bus_sel = 1'b0;
        chk(n, e, bus_rdata);
    endtask
    task automatic rst(input logic [2:0] m);
        @(negedge clock);
        rst_n = 1'b0;
        mode_pins = m;
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {prog_pump_on, erase_pump_on, prog_verify_on, erase_verify_on, bus_sel, bus_wr} = '0;
        {neg_below_reach_level, neg_above_disch_level, core_supply_low, bus_wdata} = '0;
        {prom_reg_select, prom_data_bus_in, rst_n} = '0;
        {prom_write_strobe_n, prom_output_enable_n, clk_en} = 3'h7;
        mode_pins = 3'h5;
        rst(3'h5);
        rdchk("reset", 9'h000);
        wr(9'h1ff);
        rdchk("ctrl", 9'h033);
        erase_pump_on = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr({3'h0, c[1:0], 2'h0, c[1:0]});
            erase_verify_on = 1'b0;
            repeat (2) @(negedge clock);
            chk("neg_v", neg_tab[c], neg_gate_volts);
            chk("pos_v", pos_tab[c], pos_gate_volts);
            erase_verify_on = 1'b1;
            repeat (2) @(negedge clock);
            chk("vfy_v", 4 + c, pos_gate_volts);
        end
        erase_verify_on = 1'b0;
        {neg_below_reach_level, neg_above_disch_level, core_supply_low} = 3'h7;
        repeat (5) @(negedge clock);
        rdchk("st_erase", 9'h1f3);
        erase_pump_on = 1'b0;
        prog_pump_on = 1'b1;
        repeat (5) @(negedge clock);
        rdchk("st_prog", 9'h0f3);
        prog_pump_on = 1'b0;
        repeat (5) @(negedge clock);
        rdchk("st_idle", 9'h0b3);
        {neg_below_reach_level, neg_above_disch_level, core_supply_low} = 3'h0;
        rst(3'h1);
        prom_reg_select = 3'h5;
        prom_data_bus_in = 16'hffff;
        prom_write_strobe_n = 1'b0;
        repeat (4) @(negedge clock);
        prom_write_strobe_n = 1'b1;
        repeat (8) @(negedge clock);
        prom_data_bus_in = 16'h0000;
        wr(9'h000);
        chk("oe", 16'h01ff, prom_data_bus_oe);
        chk("out", 16'h0033, prom_data_bus_out);
        prom_reg_select = 3'h0;
        repeat (5) @(negedge clock);
        chk("oe_off", 16'h0000, prom_data_bus_oe);
        for (int m = 4; m < 8; m++) begin
            rst(m[2:0]);
            chk("user", m < 6, user_program_mode);
            chk("boot", m > 5, serial_boot_select);
            chk("expand", !m[0], expanded_bus);
        end
        chk("rom0", 1, boot_rom_at_zero);
        chk("baud", 16'h0037, uart0_baud_div);
        host.send(8'ha5);
        host.send(8'h3c);
        repeat (2) @(negedge clock);
        chk("low", 1, host_low_cycles >= BIT - 1 && host_low_cycles <= BIT + 1);
        chk("lock", 1, host_rate_locked);
        chk("nwr", 2, wq.size());
        chk("a0", 32'h0803_0000, wq[0][39:8]);
        chk("d0", 8'ha5, wq[0][7:0]);
        chk("a1", 32'h0803_0001, wq[1][39:8]);
        chk("d1", 8'h3c, wq[1][7:0]);
        print_verdict();
    end
endmodule
`default_nettype wire
